// [include/strap_cfg_pkg.sv]
// package for the strap configuration latch: offsets, fields, codes, timing
// assumes one 200 MHz clock and a 32-bit classic wishbone register port
`default_nettype none

package strap_cfg_pkg;

  // register byte offsets
  localparam logic [7:0] BASIC_CTRL_OFS = 8'h00;
  localparam logic [7:0] AN_ADV_OFS     = 8'h04;
  localparam logic [7:0] STRAP_STAT_OFS = 8'h08;

  // basic control register fields
  localparam int CTRL_SPEED_BIT   = 13;
  localparam int CTRL_AN_EN_BIT   = 12;
  localparam int CTRL_ISO_BIT     = 10;
  localparam int CTRL_DUPLEX_BIT  = 8;

  // advertisement speed capability fields
  localparam int ADV_100_FD_BIT = 8;
  localparam int ADV_100_HD_BIT = 7;
  localparam int ADV_10_FD_BIT  = 6;
  localparam int ADV_10_HD_BIT  = 5;
  localparam logic [15:0] ADV_SELECTOR = 16'h0001;

  // strap status register fields
  localparam int STAT_ADDR_LSB = 0;
  localparam int STAT_MODE_LSB = 8;
  localparam int STAT_DONE_BIT = 15;

  // station address
  localparam int               STATION_ADDR_W    = 5;
  localparam logic [4:0]       STATION_ADDR_DFLT = 5'h01;

  // interface mode strap codes
  localparam logic [2:0] MODE_CODE_MII     = 3'h0;
  localparam logic [2:0] MODE_CODE_RMII    = 3'h1;
  localparam logic [2:0] MODE_CODE_PRE_RST = 3'h4;

  typedef enum logic [1:0] {
    MODE_MII,
    MODE_RMII,
    MODE_MII_PRE_RESTORE
  } iface_mode_e;

  // strap pin group, also used for pin output data and output enables
  typedef struct packed {
    logic station_addr_strap_bit2;
    logic station_addr_strap_bit1;
    logic station_addr_strap_bit0;
    logic iface_mode_strap_bit2;
    logic iface_mode_strap_bit1;
    logic iface_mode_strap_bit0;
    logic isolate_strap;
    logic speed_strap;
    logic duplex_strap;
    logic autoneg_enable_strap;
  } strap_s;

  localparam int STRAP_W = $bits(strap_s);

  // settle time of the pins after reset release, in ns
  localparam int CLK_PERIOD_NS   = 5;
  localparam int STRAP_SETTLE_NS = 20;
  localparam int STRAP_SETTLE_CYC =
    (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

`default_nettype wire

// [core/strap_config_latch.sv]
// strap configuration latch: captures dual-purpose strap pins after reset and
// seeds control, advertisement and status registers on a wishbone slave.
// assumes board pulls on the pins, a 200 MHz clock and classic wishbone.
// Function
// - sample straps after reset release, hold until next
// - pins input during reset and capture, driven afterwards
// - three address straps set address 0..7
// - address bits 4:3 zero, default 00001
// - decode mode code: MII, RMII, preamble restore
// - isolate strap high enables isolate mode
// - isolate level loads control bit 10
// - speed strap high means 100, low 10
// - speed level loads control bit 13
// - speed level sets advertised speed capability
// - duplex strap high half, low full
// - inverted duplex level loads control bit 8
// - autoneg strap high enables autonegotiation
`timescale 1ns/100ps
`default_nettype none

module strap_config_latch
  import strap_cfg_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  // strap pins, three signals each
  input  wire strap_s      strap_pin_in,
  output strap_s           strap_pin_out,
  output strap_s           strap_pin_oe_out,
  // normal-function data for the shared pins
  input  wire strap_s      pin_func_data_in,
  // classic wishbone slave
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic [31:0]      wb_dat_out,
  output logic             wb_ack_out,
  // captured configuration
  output logic [4:0]       station_addr_out,
  output iface_mode_e      iface_mode_out,
  output logic             isolate_out,
  output logic             speed_100_out,
  output logic             full_duplex_out,
  output logic             autoneg_en_out,
  output logic             capture_done_out
);

  typedef enum logic {
    ST_CAPTURE,
    ST_RUN
  } phase_e;

  phase_e      phase_reg;
  strap_s      sync1_reg;
  strap_s      sync2_reg;
  strap_s      sync3_reg;
  logic [3:0]  settle_reg;
  logic [15:0] ctrl_reg;
  logic [15:0] adv_reg;
  logic [4:0]  addr_reg;
  iface_mode_e mode_reg;
  logic        ack_reg;
  logic [31:0] rdata_reg;
  logic        latch_now;
  logic        wr_hit;
  iface_mode_e mode_next;
  logic [2:0]  mode_code;

  // three-stage pin synchroniser; only stage two and three are compared
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
    end
    else
    begin
      sync1_reg <= strap_pin_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // pins stay inputs until the settle count runs out and stages agree
  assign latch_now = (phase_reg == ST_CAPTURE) && (settle_reg == 4'(STRAP_SETTLE_CYC))
                     && (sync2_reg == sync3_reg);

  // settle counter; reset cannot sample a port, so capture follows release
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      settle_reg <= '0;
    else if (settle_reg != 4'(STRAP_SETTLE_CYC))
      settle_reg <= settle_reg + 4'h1;
  end

  // capture phase ends once, stays in run until the next reset
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      phase_reg <= ST_CAPTURE;
    else if (latch_now)
      phase_reg <= ST_RUN;
  end

  // pins are inputs with pulls while capturing, driven outputs later
  assign strap_pin_oe_out = (phase_reg == ST_RUN) ? '1 : '0;

  // output data registered from the shared function
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      strap_pin_out <= '0;
    else
      strap_pin_out <= pin_func_data_in;
  end

  // mode code in strap order, bit2 first
  assign mode_code = {sync3_reg.iface_mode_strap_bit2, sync3_reg.iface_mode_strap_bit1,
                      sync3_reg.iface_mode_strap_bit0};

  // mode decode; reserved codes fall back to plain MII
  always_comb
  begin
    unique case (mode_code)
      MODE_CODE_RMII:    mode_next = MODE_RMII;
      MODE_CODE_PRE_RST: mode_next = MODE_MII_PRE_RESTORE;
      default:           mode_next = MODE_MII;
    endcase
  end

  // address and mode captured once; upper address bits stay zero
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      addr_reg <= STATION_ADDR_DFLT;
      mode_reg <= MODE_MII;
    end
    else if (latch_now)
    begin
      addr_reg <= {2'b00, sync3_reg.station_addr_strap_bit2,
                   sync3_reg.station_addr_strap_bit1,
                   sync3_reg.station_addr_strap_bit0};
      mode_reg <= mode_next;
    end
  end

  // write strobe for the single-cycle classic answer
  assign wr_hit = wb_cyc_in && wb_stb_in && wb_we_in && !ack_reg;

  // basic control: seeded by straps, then writable by software
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      ctrl_reg <= '0;
    else if (latch_now)
    begin
      ctrl_reg                  <= '0;
      ctrl_reg[CTRL_ISO_BIT]    <= sync3_reg.isolate_strap;
      ctrl_reg[CTRL_SPEED_BIT]  <= sync3_reg.speed_strap;
      ctrl_reg[CTRL_DUPLEX_BIT] <= !sync3_reg.duplex_strap;
      ctrl_reg[CTRL_AN_EN_BIT]  <= sync3_reg.autoneg_enable_strap;
    end
    else if (wr_hit && wb_adr_in == BASIC_CTRL_OFS)
    begin
      // all four control bits sit in byte lane 1
      if (wb_sel_in[1])
      begin
        ctrl_reg[CTRL_DUPLEX_BIT] <= wb_dat_in[CTRL_DUPLEX_BIT];
        ctrl_reg[CTRL_ISO_BIT]   <= wb_dat_in[CTRL_ISO_BIT];
        ctrl_reg[CTRL_SPEED_BIT] <= wb_dat_in[CTRL_SPEED_BIT];
        ctrl_reg[CTRL_AN_EN_BIT] <= wb_dat_in[CTRL_AN_EN_BIT];
      end
    end
  end

  // advertisement: speed strap decides which speeds are offered
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      adv_reg <= ADV_SELECTOR;
    else if (latch_now)
    begin
      adv_reg                 <= ADV_SELECTOR;
      adv_reg[ADV_100_FD_BIT] <= sync3_reg.speed_strap;
      adv_reg[ADV_100_HD_BIT] <= sync3_reg.speed_strap;
      adv_reg[ADV_10_FD_BIT]  <= 1'b1;
      adv_reg[ADV_10_HD_BIT]  <= 1'b1;
    end
    else if (wr_hit && wb_adr_in == AN_ADV_OFS)
    begin
      // bit 8 sits in lane 1, bits 7..5 in lane 0
      if (wb_sel_in[1])
        adv_reg[ADV_100_FD_BIT] <= wb_dat_in[ADV_100_FD_BIT];
      if (wb_sel_in[0])
      begin
        adv_reg[ADV_100_HD_BIT] <= wb_dat_in[ADV_100_HD_BIT];
        adv_reg[ADV_10_FD_BIT]  <= wb_dat_in[ADV_10_FD_BIT];
        adv_reg[ADV_10_HD_BIT]  <= wb_dat_in[ADV_10_HD_BIT];
      end
    end
  end

  // one-cycle answer to every address; unmapped reads zero, writes dropped
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      ack_reg <= 1'b0;
    else
      ack_reg <= wb_cyc_in && wb_stb_in && !ack_reg;
  end

  // read data registered with the answer
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      rdata_reg <= '0;
    else if (wb_cyc_in && wb_stb_in && !ack_reg)
    begin
      unique case (wb_adr_in)
        BASIC_CTRL_OFS: rdata_reg <= {16'h0000, ctrl_reg};
        AN_ADV_OFS:     rdata_reg <= {16'h0000, adv_reg};
        STRAP_STAT_OFS:
        begin
          rdata_reg                                    <= '0;
          rdata_reg[STAT_ADDR_LSB +: STATION_ADDR_W]   <= addr_reg;
          rdata_reg[STAT_MODE_LSB +: $bits(iface_mode_e)] <= mode_reg;
          rdata_reg[STAT_DONE_BIT]                     <= (phase_reg == ST_RUN);
        end
        default:        rdata_reg <= '0;
      endcase
    end
  end

  assign wb_ack_out = ack_reg;
  assign wb_dat_out = rdata_reg;

  // configuration outputs straight from the registers
  assign station_addr_out = addr_reg;
  assign iface_mode_out   = mode_reg;
  assign isolate_out      = ctrl_reg[CTRL_ISO_BIT];
  assign speed_100_out    = ctrl_reg[CTRL_SPEED_BIT];
  assign full_duplex_out  = ctrl_reg[CTRL_DUPLEX_BIT];
  assign autoneg_en_out   = ctrl_reg[CTRL_AN_EN_BIT];
  assign capture_done_out = (phase_reg == ST_RUN);

  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  sequence s_capture;
    latch_now;
  endsequence

  sequence s_run_after;
    ##1 (phase_reg == ST_RUN);
  endsequence

  a_latch_once: assert property ((phase_reg == ST_RUN) |=> (phase_reg == ST_RUN))
    else $error("capture phase re-entered without reset");

  a_pins_released: assert property (
    (phase_reg == ST_CAPTURE) |-> (strap_pin_oe_out == '0))
    else $error("strap pin driven during capture");

  a_pins_driven: assert property (
    s_capture |-> s_run_after ##0 (strap_pin_oe_out == '1))
    else $error("strap pin not driven after capture");

  a_addr_taken: assert property (
    s_capture |=> (addr_reg[2:0] == {$past(sync3_reg.station_addr_strap_bit2),
      $past(sync3_reg.station_addr_strap_bit1), $past(sync3_reg.station_addr_strap_bit0)}))
    else $error("station address not taken from straps");

  a_addr_upper: assert property (station_addr_out[4:3] == 2'b00)
    else $error("station address upper bits not zero");

  // antecedent from the raw code, so a broken decode cannot hide itself
  a_mode_fallback: assert property (
    (s_capture and (mode_code != MODE_CODE_RMII && mode_code != MODE_CODE_PRE_RST))
      |=> (mode_reg == MODE_MII) [*2])
    else $error("reserved mode not mapped to MII");

  a_iso_loaded: assert property (
    s_capture |=> isolate_out == $past(sync3_reg.isolate_strap))
    else $error("isolate bit not loaded");

  a_speed_loaded: assert property (
    s_capture |=> speed_100_out == $past(sync3_reg.speed_strap)
      && adv_reg[ADV_100_HD_BIT] == $past(sync3_reg.speed_strap))
    else $error("speed bit or capability not loaded");

  a_duplex_loaded: assert property (
    s_capture |=> full_duplex_out == !$past(sync3_reg.duplex_strap))
    else $error("duplex bit not loaded inverted");

  a_an_loaded: assert property (
    s_capture |=> autoneg_en_out == $past(sync3_reg.autoneg_enable_strap))
    else $error("autoneg enable not seeded");

  a_ack_pulse: assert property (wb_cyc_in && wb_stb_in && !ack_reg |=> ack_reg ##1 !ack_reg)
    else $error("wishbone answer not a single cycle pulse");

endmodule

`default_nettype wire

// [test/board_pulls.sv]
// board pull resistors on the shared strap pins, resolving each pin level
// assumes the latch drives a pin only while its enable bit is high
`timescale 1ns/100ps
`default_nettype none

module board_pulls
  import strap_cfg_pkg::*;
(
  input  wire strap_s pull_up_in,
  input  wire strap_s drv_in,
  input  wire strap_s oe_in,
  output wire strap_s level_out
);
  // a released pin falls to its pull level, never keeps the last value
  assign level_out = (oe_in & drv_in) | (~oe_in & pull_up_in);
endmodule

`default_nettype wire

// [test/phy_strap_config_latch_tb_top.sv]
// bench for the strap latch: strap patterns from a table, then odd cases
// assumes the board pull model and a wishbone slave answering in one cycle
`timescale 1ns/100ps
`default_nettype none

module phy_strap_config_latch_tb_top
  import strap_cfg_pkg::*;
;
  logic        clk_in = 1'b0;
  logic        rstn_in = 1'b0;
  strap_s      pulls = '0, func_d = '0, pin_lvl, pin_o, pin_oe;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'hf;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic        ack, iso, spd, fdx, anen, done;
  logic [4:0]  saddr;
  iface_mode_e mode;
  int          fail_count = 0, cmp_count = 0;
  logic [11:0] rows [8] = '{12'h087, 12'h518, 12'h1a5, 12'h23e,
                            12'hac3, 12'h359, 12'h3e6, 12'h0fc};
  logic [15:0] e_ctrl, e_adv, e_stat;
  strap_s      s;

  // half period of 2.5 ns gives 200 MHz
  always #2.5 clk_in = ~clk_in;

  board_pulls pulls_u (.pull_up_in(pulls), .drv_in(pin_o), .oe_in(pin_oe),
                       .level_out(pin_lvl));

  strap_config_latch dut_u (
    .clk_in(clk_in), .rstn_in(rstn_in), .strap_pin_in(pin_lvl),
    .strap_pin_out(pin_o), .strap_pin_oe_out(pin_oe), .pin_func_data_in(func_d),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
    .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .station_addr_out(saddr), .iface_mode_out(mode), .isolate_out(iso),
    .speed_100_out(spd), .full_duplex_out(fdx), .autoneg_en_out(anen),
    .capture_done_out(done));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk_in);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) chk("ack", 32'h1, 32'h0);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_in);
  endtask

  // reset for 10 cycles, then wait for the capture with a bound
  task automatic do_reset();
    int n;
    rstn_in <= 1'b0;
    repeat (10) @(posedge clk_in);
    chk("oe_in_reset", 32'h0, 32'(pin_oe));
    chk("addr_in_reset", 32'h1, 32'(saddr));
    rstn_in <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end while (done !== 1'b1 && n < 50);
    chk("done", 32'h1, 32'(done));
  endtask

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // about 25 cycles a row, so 20000 cycles is ample
  initial
  begin
    #(20000 * 5);
    fail_count++;
    print_verdict();
  end

  initial
  begin
    foreach (rows[i])
    begin
      pulls <= strap_s'(rows[i][9:0]);
      s = strap_s'(rows[i][9:0]);
      do_reset();
      e_ctrl = {2'b0, s.speed_strap, s.autoneg_enable_strap, 1'b0, s.isolate_strap,
                1'b0, ~s.duplex_strap, 8'h00};
      e_adv = {7'h0, s.speed_strap, s.speed_strap, 2'b11, 5'h01};
      e_stat = {1'b1, 5'h0, rows[i][11:10], 3'h0, 2'b00, s.station_addr_strap_bit2,
                s.station_addr_strap_bit1, s.station_addr_strap_bit0};
      wb(1'b0, BASIC_CTRL_OFS, 32'h0, q);
      chk("ctrl", {16'h0, e_ctrl}, q);
      wb(1'b0, AN_ADV_OFS, 32'h0, q);
      chk("adv", {16'h0, e_adv}, q);
      wb(1'b0, STRAP_STAT_OFS, 32'h0, q);
      chk("stat", {16'h0, e_stat}, q);
      chk("addr_port", 32'(e_stat[4:0]), 32'(saddr));
      chk("mode_port", 32'(rows[i][11:10]), 32'(mode));
      chk("iso_port", 32'(s.isolate_strap), 32'(iso));
      chk("spd_port", 32'(s.speed_strap), 32'(spd));
      chk("fdx_port", 32'(!s.duplex_strap), 32'(fdx));
    end
    // autoneg enable is overridable by software after capture
    // last row captured autoneg off, so setting it proves the override
    wb(1'b1, BASIC_CTRL_OFS, 32'h0000_1000, q);
    wb(1'b0, BASIC_CTRL_OFS, 32'h0, q);
    chk("ctrl_wr", 32'h1000, q);
    chk("anen_port", 32'h1, 32'(anen));
    // lane 0 alone reaches no control bit, but the low capability bits
    sel <= 4'h1;
    wb(1'b1, BASIC_CTRL_OFS, 32'h0000_ffff, q);
    wb(1'b1, AN_ADV_OFS, 32'h0, q);
    sel <= 4'hf;
    wb(1'b0, BASIC_CTRL_OFS, 32'h0, q);
    chk("ctrl_lane", 32'h1000, q);
    wb(1'b0, AN_ADV_OFS, 32'h0, q);
    chk("adv_lane", 32'h0101, q);
    // status is read only; unmapped place reads zero
    wb(1'b1, STRAP_STAT_OFS, 32'hffff_ffff, q);
    wb(1'b0, 8'h0c, 32'h0, q);
    chk("unmapped", 32'h0, q);
    // pins now driven outputs; their new levels must not reach the latch
    func_d <= strap_s'(10'h2aa);
    repeat (3) @(posedge clk_in);
    chk("pin_out", 32'h2aa, 32'(pin_o));
    chk("pin_oe", 32'h3ff, 32'(pin_oe));
    wb(1'b0, STRAP_STAT_OFS, 32'h0, q);
    chk("stat_hold", {16'h0, e_stat}, q);
    print_verdict();
  end
endmodule

`default_nettype wire
